/* hw/hpf_pkg.sv */
package hpf_pkg;

  // interface select strap codes
  localparam logic [1:0] HPF_BIS_MUX = 2'h0;
  localparam logic [1:0] HPF_BIS_NONMUX = 2'h1;
  localparam logic [1:0] HPF_BIS_SERIAL = 2'h2;
  localparam logic [1:0] HPF_BIS_HW = 2'h3;

  typedef enum logic [3:0] {
    HPF_MODE_MUX = 4'h1,
    HPF_MODE_NONMUX = 4'h2,
    HPF_MODE_SERIAL = 4'h4,
    HPF_MODE_HW = 4'h8
  } hpf_mode_t;

  // line family codes held in the control register
  localparam logic [1:0] HPF_FAM_T1E1 = 2'h0;
  localparam logic [1:0] HPF_FAM_CC64 = 2'h1;

  // register byte offsets
  localparam logic [7:0] HPF_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] HPF_STATUS_OFFSET = 8'h04;

  // control register fields
  localparam int HPF_CTRL_ALARM_N_BIT = 0;
  localparam int HPF_CTRL_TERM75_BIT = 1;
  localparam int HPF_CTRL_FAM_LSB = 2;
  localparam logic [7:0] HPF_CTRL_RESET = 8'h01;

  // status register fields
  localparam int HPF_STAT_MODE_LSB = 0;
  localparam int HPF_STAT_ZSUB_BIT = 4;
  localparam int HPF_STAT_AIS_BIT = 5;
  localparam int HPF_STAT_ONES_BIT = 6;
  localparam int HPF_STAT_TERM120_BIT = 7;
  localparam int HPF_STAT_TAKEN_BIT = 8;

  localparam logic [1:0] HPF_RESP_OKAY = 2'h0;
  localparam logic [1:0] HPF_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic rx_operating_select_bit3;
    logic master_clock_prescale_bit0;
    logic tx_operating_select_bit0;
    logic [2:0] line_buildout;
    logic term_120_ohm;
    logic zero_substitution_enable;
  } hpf_hw_cfg_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [1:0] wdata;
    logic rd;
    logic wr;
    logic addr_strobe;
  } hpf_host_bus_t;

  typedef struct packed {
    logic active;
    logic mosi;
    logic cpol;
    logic cpha;
  } hpf_spi_cfg_t;

  typedef struct packed {
    logic send_ais;
    logic send_all_ones;
  } hpf_tx_force_t;

endpackage

/* hw/hpf_pin_decode.sv */
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
// Contract
// - strap 01 makes low shared pins separate data bits D1 and D0.
// - strap 00 makes shared pins multiplexed address then data lines.
// - hardware mode reads data bit 1 pin as receive mode select bit 3.
// - serial mode takes MOSI on data bit 1, drives MISO on bit 0.
// - address pins A6..A0 used in non-multiplexed mode, ignored in multiplexed.
// - hardware mode reads address bit 6 as clock prescale select bit 0.
// - serial mode reads address bit 5 as serial clock polarity.
// - serial mode reads address bit 4 as serial clock phase.
// - hardware mode reads address bit 5 as transmit mode select bit 0.
// - hardware mode takes address bits 4..2 as line build-out.
// - T1/E1 modes send alarm pattern while address bit 1 is low; outside hardware mode the control register alarm bit does this instead.
// - composite clock modes send all-ones without violations while pin low; outside hardware mode the control register alarm bit does this instead.
// - hardware mode: address bit 0 low picks 120 ohm, high 75 ohm.
// - bus style strap high: strobe, address strobe, read/write pins.
// - hardware mode T1/E1 enables zero substitution when style pin high.
// - strap decode 00 mux, 01 non-mux, 10 serial, 11 hardware.
// - multiplexed mode captures address on rising address latch edge.
module hpf_pin_decode
  import hpf_pkg::*;
#(
  parameter int AXI_ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] bus_interface_select,
  input wire logic bus_style_strap,
  input wire logic d1_in,
  output logic d1_out,
  output logic d1_oe,
  input wire logic d0_in,
  output logic d0_out,
  output logic d0_oe,
  input wire logic [6:0] addr_pins,
  input wire logic latch_pin,
  input wire logic read_strobe_pin,
  input wire logic write_pin,
  input wire logic chip_select_n,
  input wire logic [1:0] read_data,
  input wire logic miso_data,
  output hpf_mode_t mode,
  output hpf_host_bus_t host_bus,
  output hpf_spi_cfg_t spi_cfg,
  output hpf_hw_cfg_t hw_cfg,
  output hpf_tx_force_t tx_force
);

  if (AXI_ADDR_W < 3 || AXI_ADDR_W > 32) begin : g_bad_width
    $error("AXI_ADDR_W must lie between 3 and 32");
  end

  // strap capture: taken once, on the first edge after reset release,
  // so a strap that moves later cannot flip the pin functions mid-access
  hpf_mode_t next_mode;
  logic strap_taken;

  always_comb begin
    unique case (bus_interface_select)
      HPF_BIS_MUX: next_mode = HPF_MODE_MUX;
      HPF_BIS_NONMUX: next_mode = HPF_MODE_NONMUX;
      HPF_BIS_SERIAL: next_mode = HPF_MODE_SERIAL;
      HPF_BIS_HW: next_mode = HPF_MODE_HW;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= HPF_MODE_MUX;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      mode <= next_mode;
      strap_taken <= 1'b1;
    end
  end

  wire is_mux = (mode == HPF_MODE_MUX);
  wire is_nonmux = (mode == HPF_MODE_NONMUX);
  wire is_serial = (mode == HPF_MODE_SERIAL);
  wire is_hw = (mode == HPF_MODE_HW);
  wire is_par = is_mux | is_nonmux;
  wire selected = ~chip_select_n;

  // control register, software side of the loose bits
  logic [7:0] ctrl;
  wire ctrl_alarm_n = ctrl[HPF_CTRL_ALARM_N_BIT];
  wire ctrl_term75 = ctrl[HPF_CTRL_TERM75_BIT];
  wire [1:0] family = ctrl[HPF_CTRL_FAM_LSB +: 2];
  wire fam_t1e1 = (family == HPF_FAM_T1E1);
  wire fam_cc64 = (family == HPF_FAM_CC64);

  // bus style: strobes decoded from the read and write pins
  // data strobe is high-active in non-multiplexed mode, low-active in multiplexed mode
  wire ds_active = is_nonmux ? read_strobe_pin : ~read_strobe_pin;
  wire style_rd = bus_style_strap ? (ds_active & write_pin)
                                  : ~read_strobe_pin;
  wire style_wr = bus_style_strap ? (ds_active & ~write_pin)
                                  : ~write_pin;
  wire par_rd = is_par & selected & style_rd;
  wire par_wr = is_par & selected & style_wr;

  // address latch in multiplexed mode
  logic latch_q;
  logic [1:0] mux_addr;
  wire latch_rise = latch_pin & ~latch_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= 1'b0;
      mux_addr <= 2'h0;
    end else begin
      latch_q <= latch_pin;
      if (is_mux && latch_rise) begin
        mux_addr <= {d1_in, d0_in};
      end
    end
  end

  // upper multiplexed address bits are tied to zero; only the two latched shared-pin bits form the address
  wire [6:0] next_addr = is_nonmux ? addr_pins
                                   : {5'h00, mux_addr};

  hpf_host_bus_t next_host_bus;
  assign next_host_bus.addr = is_par ? next_addr : 7'h00;
  assign next_host_bus.wdata = is_par ? {d1_in, d0_in} : 2'h0;
  assign next_host_bus.rd = par_rd;
  assign next_host_bus.wr = par_wr;
  assign next_host_bus.addr_strobe = is_mux & latch_rise;

  hpf_spi_cfg_t next_spi;
  assign next_spi.active = is_serial & selected;
  assign next_spi.mosi = is_serial & d1_in;
  assign next_spi.cpol = is_serial & addr_pins[5];
  assign next_spi.cpha = is_serial & addr_pins[4];

  // alarm force: pin in hardware mode, register bit otherwise
  wire alarm_n = is_hw ? addr_pins[1] : ctrl_alarm_n;

  hpf_tx_force_t next_force;
  assign next_force.send_ais = fam_t1e1 & ~alarm_n;
  assign next_force.send_all_ones = fam_cc64 & ~alarm_n;

  hpf_hw_cfg_t next_hw;
  assign next_hw.rx_operating_select_bit3 = is_hw & d1_in;
  assign next_hw.master_clock_prescale_bit0 =
    is_hw & addr_pins[6];
  assign next_hw.tx_operating_select_bit0 = is_hw & addr_pins[5];
  assign next_hw.line_buildout = is_hw ? addr_pins[4:2] : 3'h0;
  assign next_hw.term_120_ohm = is_hw ? ~addr_pins[0]
                                      : ~ctrl_term75;
  assign next_hw.zero_substitution_enable =
    is_hw & fam_t1e1 & bus_style_strap;

  // shared data pin drivers
  wire next_par_oe = par_rd;
  wire next_miso_oe = is_serial & selected;
  wire next_d0_out = is_serial ? miso_data : read_data[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_bus <= '0;
      spi_cfg <= '0;
      tx_force <= '0;
      hw_cfg <= '0;
    end else begin
      host_bus <= next_host_bus;
      spi_cfg <= next_spi;
      tx_force <= next_force;
      hw_cfg <= next_hw;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      d1_out <= 1'b0;
      d1_oe <= 1'b0;
      d0_out <= 1'b0;
      d0_oe <= 1'b0;
    end else begin
      d1_out <= read_data[1];
      d1_oe <= next_par_oe; // d1 stays an input in serial mode
      d0_out <= next_d0_out;
      d0_oe <= next_par_oe | next_miso_oe;
    end
  end

  // AXI4-Lite slave: address and data are taken in either order,
  // the response goes out one edge after both are held
  logic aw_held;
  logic w_held;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [7:0] w_byte0;
  logic w_lane0;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_held & w_held;
  wire wr_ctrl = (aw_addr == AXI_ADDR_W'(HPF_CTRL_OFFSET));
  wire wr_stat = (aw_addr == AXI_ADDR_W'(HPF_STATUS_OFFSET));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (aw_fire) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte0 <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (w_fire) begin
      w_held <= 1'b1;
      w_byte0 <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= HPF_CTRL_RESET;
    end else if (do_write && wr_ctrl && w_lane0) begin
      ctrl <= w_byte0;
    end
  end

  // status is read-only: a write there is accepted and has no effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= HPF_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ctrl | wr_stat) ? HPF_RESP_OKAY
                                         : HPF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  wire [31:0] status_word = {
    23'h000000,
    strap_taken,
    hw_cfg.term_120_ohm,
    tx_force.send_all_ones,
    tx_force.send_ais,
    hw_cfg.zero_substitution_enable,
    mode
  };
  assign s_axi_arready = ~s_axi_rvalid;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire rd_ctrl = (s_axi_araddr == AXI_ADDR_W'(HPF_CTRL_OFFSET));
  wire rd_stat = (s_axi_araddr == AXI_ADDR_W'(HPF_STATUS_OFFSET));
  wire [31:0] rd_word = rd_ctrl ? {24'h000000, ctrl}
                      : rd_stat ? status_word : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= HPF_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (rd_ctrl | rd_stat) ? HPF_RESP_OKAY
                                         : HPF_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

/* verification/hpf_checker.sv */
`timescale 1ns/10ps
module hpf_checker
  import hpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] bus_interface_select,
  input wire logic bus_style_strap,
  input wire logic d1_in,
  input wire logic d1_oe,
  input wire logic d0_out,
  input wire logic d0_oe,
  input wire logic [6:0] addr_pins,
  input wire logic latch_pin,
  input wire logic read_strobe_pin,
  input wire logic write_pin,
  input wire logic chip_select_n,
  input wire logic miso_data,
  input hpf_mode_t mode,
  input hpf_host_bus_t host_bus,
  input hpf_spi_cfg_t spi_cfg,
  input hpf_hw_cfg_t hw_cfg
);
  // mode still holds its reset value at the first edge after release
  logic live;
  always_ff @(posedge aclk) live <= aresetn;
  wire ser = live && mode == HPF_MODE_SERIAL;
  wire hw = live && mode == HPF_MODE_HW;
  wire par = live && (mode == HPF_MODE_MUX || mode == HPF_MODE_NONMUX);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  mode_decode_a: assert property ($rose(aresetn) |=>
    mode == 4'(4'h1 << $past(bus_interface_select))) else $error("bad mode");
  nonmux_addr_a: assert property (live && mode == HPF_MODE_NONMUX |=>
    host_bus.addr == $past(addr_pins)) else $error("bad address");
  addr_latch_a: assert property (live && mode == HPF_MODE_MUX &&
    !chip_select_n && $rose(latch_pin) |=> ##[0:1] host_bus.addr_strobe)
    else $error("no latch");
  split_strobe_a: assert property (par && !bus_style_strap &&
    !chip_select_n |=> host_bus.rd == !$past(read_strobe_pin) &&
    host_bus.wr == !$past(write_pin)) else $error("bad strobes");
  spi_cfg_a: assert property (ser |=> spi_cfg.mosi == $past(d1_in) &&
    spi_cfg.cpol == $past(addr_pins[5]) &&
    spi_cfg.cpha == $past(addr_pins[4])) else $error("bad spi");
  miso_drive_a: assert property (ser && !chip_select_n |=>
    d0_oe && d0_out == $past(miso_data)) else $error("bad miso");
  pins_idle_a: assert property (live && (chip_select_n ||
    mode == HPF_MODE_HW) |=> !d0_oe && !d1_oe) else $error("pin driven");
  hw_straps_a: assert property (hw |=> hw_cfg[7:1] ==
    {$past(d1_in), $past(addr_pins[6:2]), !$past(addr_pins[0])})
    else $error("bad straps");
  zsub_off_a: assert property (hw && !bus_style_strap |=>
    !hw_cfg.zero_substitution_enable) else $error("bad zsub");
endmodule
bind hpf_pin_decode hpf_checker chk_u (.aclk, .aresetn, .bus_interface_select,
  .bus_style_strap, .d1_in, .d1_oe, .d0_out, .d0_oe, .addr_pins, .latch_pin,
  .read_strobe_pin, .write_pin, .chip_select_n, .miso_data, .mode, .host_bus,
  .spi_cfg, .hw_cfg);

/* verification/hpf_host_model.sv */
`timescale 1ns/10ps
module hpf_host_model (
  input wire logic aclk,
  input wire logic [1:0] host_d,
  input wire logic [1:0] host_oe,
  input wire logic [1:0] dev_d,
  input wire logic [1:0] dev_oe,
  output logic [1:0] pin
);
  logic [1:0] last = 2'h0;
  // a floating pin toggles so a stale level is never mistaken for data
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin[i] = dev_oe[i] ? dev_d[i] : host_oe[i] ? host_d[i] : ~last[i];
    end
  end
  // plain process: the variable also carries a declaration-time start value
  always @(posedge aclk) last <= pin;
endmodule

/* verification/test_hpf_pin_decode.sv */
`timescale 1ns/10ps
module test_hpf_pin_decode
  import hpf_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [1:0] bus_interface_select = 2'h0, read_data = 2'h0;
  logic [1:0] host_d = 2'h0, host_oe = 2'h0;
  logic bus_style_strap = 1'b0, latch_pin = 1'b0, read_strobe_pin = 1'b1;
  logic write_pin = 1'b1, chip_select_n = 1'b1, miso_data = 1'b0;
  logic [6:0] addr_pins = 7'h0;
  wire d1_in, d1_out, d1_oe, d0_in, d0_out, d0_oe;
  hpf_mode_t mode;
  hpf_host_bus_t host_bus;
  hpf_spi_cfg_t spi_cfg;
  hpf_hw_cfg_t hw_cfg;
  hpf_tx_force_t tx_force;
  int fails = 0, checks = 0;
  logic [1:0] resp;
  logic [31:0] rword;
  localparam logic [7:0] CV [4] = '{8'h04, 8'h05, 8'h00, 8'h01};
  localparam logic [1:0] FV [4] = '{2'h1, 2'h0, 2'h2, 2'h0};

  hpf_pin_decode dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .bus_interface_select, .bus_style_strap, .d1_in, .d1_out, .d1_oe, .d0_in,
    .d0_out, .d0_oe, .addr_pins, .latch_pin, .read_strobe_pin, .write_pin,
    .chip_select_n, .read_data, .miso_data, .mode, .host_bus, .spi_cfg,
    .hw_cfg, .tx_force);
  hpf_host_model host_u (.aclk, .host_d, .host_oe, .dev_d({d1_out, d0_out}),
    .dev_oe({d1_oe, d0_oe}), .pin({d1_in, d0_in}));

  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tick;
    repeat (2) @(posedge aclk);
  endtask

  task automatic boot(input logic [1:0] s);
    @(posedge aclk);
    aresetn <= 1'b0;
    bus_interface_select <= s;
    chip_select_n <= 1'b1;
    host_oe <= 2'h0;
    addr_pins <= 7'h0;
    bus_style_strap <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rword = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_mux;
    boot(HPF_BIS_MUX);
    chip_select_n <= 1'b0;
    host_oe <= 2'h3;
    host_d <= 2'h2;
    @(posedge aclk);
    latch_pin <= 1'b1;
    tick;
    @(posedge aclk);
    chk("addr", 32'(host_bus.addr), 32'h2);
    latch_pin <= 1'b0;
    host_d <= 2'h1;
    write_pin <= 1'b0;
    tick;
    chk("wdata", 32'({host_bus.wr, host_bus.wdata}), 32'h5);
    write_pin <= 1'b1;
    host_oe <= 2'h0;
    read_data <= 2'h2;
    read_strobe_pin <= 1'b0;
    tick;
    chk("drive", 32'({d1_oe, d0_oe, d1_in, d0_in}), 32'he);
    read_strobe_pin <= 1'b1;
    chip_select_n <= 1'b1;
    axr(HPF_STATUS_OFFSET);
    chk("status", 32'(rword[3:0]), 32'h1);
    axr(HPF_CTRL_OFFSET);
    chk("ctrl", rword, 32'h1);
    axr(8'h10);
    chk("unmapped", 32'(resp), 32'(HPF_RESP_SLVERR));
    for (int i = 0; i < 4; i++) begin
      axw(HPF_CTRL_OFFSET, 32'(CV[i]));
      chk("bresp", 32'(resp), 32'(HPF_RESP_OKAY));
      tick;
      chk("force", 32'(tx_force), 32'(FV[i]));
    end
    axw(8'h10, 32'h00000000);
    chk("bresp_unmapped", 32'(resp), 32'(HPF_RESP_SLVERR));
  endtask

  task automatic t_nonmux;
    boot(HPF_BIS_NONMUX);
    bus_style_strap <= 1'b1;
    chip_select_n <= 1'b0;
    addr_pins <= 7'h5a;
    host_oe <= 2'h3;
    host_d <= 2'h3;
    write_pin <= 1'b0;
    tick;
    chk("naddr", 32'(host_bus.addr), 32'h5a);
    chk("nwrite", 32'({host_bus.rd, host_bus.wr, host_bus.wdata}),
      32'h7);
    write_pin <= 1'b1;
    host_oe <= 2'h0;
    read_data <= 2'h1;
    tick;
    chk("nread", 32'({host_bus.rd, host_bus.wr, d1_in, d0_in}),
      32'h9);
  endtask

  task automatic t_serial;
    boot(HPF_BIS_SERIAL);
    chip_select_n <= 1'b0;
    host_oe <= 2'h2;
    for (int i = 0; i < 2; i++) begin
      addr_pins <= i ? 7'h10 : 7'h20;
      host_d <= i ? 2'h0 : 2'h2;
      miso_data <= (i == 0);
      tick;
      chk("spi", 32'({spi_cfg.active, spi_cfg.mosi, spi_cfg.cpol,
        spi_cfg.cpha}), i ? 32'h9 : 32'he);
      chk("miso", 32'({d0_oe, d0_out, d1_oe}),
        i ? 32'h4 : 32'h6);
    end
    chip_select_n <= 1'b1;
    tick;
    chk("miso_off", 32'(d0_oe), 32'h0);
  endtask

  task automatic t_hw;
    boot(HPF_BIS_HW);
    host_oe <= 2'h2;
    for (int i = 0; i < 2; i++) begin
      addr_pins <= i ? 7'h2a : 7'h55;
      host_d <= i ? 2'h0 : 2'h2;
      bus_style_strap <= (i == 0);
      tick;
      chk("hw", 32'(hw_cfg),
        i ? 32'h2a : 32'hd5);
      chk("ais", 32'(tx_force), i ? 32'h0 : 32'h2);
    end
  endtask

  task automatic report_and_stop;
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    t_mux;
    t_nonmux;
    t_serial;
    t_hw;
    report_and_stop;
  end

  initial begin
    repeat (3000) @(posedge aclk);
    fails++;
    report_and_stop;
  end
endmodule
